// [fpsa_pkg.sv]
// shared constants and types for the flash protect/status/abort host controller
package fpsa_pkg;
  // status register bit positions on the device
  localparam int unsigned ST_READY_BIT    = 7;
  localparam int unsigned ST_RSVD_HI_BIT  = 6;
  localparam int unsigned ST_ERASE_FAIL   = 5;
  localparam int unsigned ST_PROG_FAIL    = 4;
  localparam int unsigned ST_PROTECT_BIT  = 3;
  localparam int unsigned ST_RSVD_LO_BIT  = 2;
  localparam logic [7:0]  ST_POLL_MASK    = 8'hBB;  // reserved bits 6 and 2 masked
  // command bytes
  localparam logic [7:0]  CMD_UNLOCK1     = 8'hAA;
  localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
  localparam logic [7:0]  CMD_SETUP       = 8'h60;
  localparam logic [7:0]  CMD_LOCK        = 8'h20;
  localparam logic [7:0]  CMD_UNPROTECT   = 8'h40;
  localparam logic [7:0]  CMD_ABORT       = 8'hE0;
  localparam logic [7:0]  CMD_READ_ARRAY  = 8'hF0;
  localparam logic [7:0]  CMD_CLR_STATUS  = 8'h50;
  localparam logic [7:0]  CMD_READ_ID     = 8'h90;
  localparam logic [7:0]  CMD_READ_STATUS = 8'h70;
  localparam logic [19:0] UNLOCK_ADDR1    = 20'h05555;
  localparam logic [19:0] UNLOCK_ADDR2    = 20'h02AAA;
  localparam logic [19:0] ID_MFR_ADDR     = 20'h00000;
  localparam logic [19:0] ID_DEV_ADDR     = 20'h00001;
  localparam logic [19:0] ID_PROT_ADDR    = 20'h00002;
  // pin timing, ns, rounded up to whole 5 ns cycles
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned T_WP_NS         = 60;
  localparam int unsigned T_WPH_NS        = 40;
  localparam int unsigned T_SRA_NS        = 120;
  localparam logic [7:0]  WP_CYC  = 8'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  WPH_CYC = 8'((T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  RD_CYC  = 8'((T_SRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // host register offsets
  localparam logic [3:0]  REG_CTRL        = 4'h0;  // write: op code in [2:0], addr in [27:8]
  localparam logic [3:0]  REG_STATUS      = 4'h1;  // read: busy, done, last status
  localparam logic [3:0]  REG_DATA        = 4'h2;  // read: last read data
  // host operations
  typedef enum logic [2:0] {
    OP_LOCK      = 3'h0,
    OP_UNPROTECT = 3'h1,
    OP_ABORT     = 3'h2,
    OP_READ_ARR  = 3'h3,
    OP_CLR_STAT  = 3'h4,
    OP_READ_ID   = 3'h5,
    OP_POLL      = 3'h6,
    OP_READ      = 3'h7
  } fpsa_op_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_LOW   = 3'h2,
    ST_HIGH  = 3'h3,
    ST_NEXT  = 3'h4,
    ST_RDLOW = 3'h5,
    ST_RDEND = 3'h6
  } fpsa_state_t;
endpackage

// [fpsa_cyc_if.sv]
// one bus-cycle request/answer between sequencer and pin engine
`timescale 1ns/1ps
interface fpsa_cyc_if;
  logic        req;    // one-cycle start pulse
  logic        wr;     // 1 write cycle, 0 read cycle
  logic [19:0] addr;   // address for the cycle
  logic [7:0]  wdata;  // command byte
  logic        done;   // one-cycle completion pulse
  logic [7:0]  rdata;  // captured read data
  modport seq (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

// [fpsa_pin_eng.sv]
// pin engine: drives one write or read bus cycle on the flash pins
`timescale 1ns/1ps
module fpsa_pin_eng
  import fpsa_pkg::*;
(
  input  wire logic  clk_i,      // 200 MHz clock
  input  wire logic  rst_i,      // synchronous reset
  fpsa_cyc_if.eng    cyc,        // cycle request/answer
  input  wire logic [7:0] dq_i,  // data pins, from the device
  output logic [7:0] dq_o,       // data pins, to the device
  output logic       dq_oe_o,    // data pin drive enable
  output logic [19:0] addr_o,    // address pins
  output logic       ce_n_o,     // chip enable, active low
  output logic       oe_n_o      // output enable, active low
);
  typedef struct packed {
    fpsa_state_t st;
    logic [7:0]  cnt;
    logic [7:0]  d;
    logic        dq_oe;
    logic [19:0] a;
    logic        ce_n;
    logic        oe_n;
    logic        done;
    logic [7:0]  rd;
    logic [7:0]  s1;
    logic [7:0]  s2;
  } eng_t;
  eng_t st_ff, nxt_st;

  // sequence: address set with ce high, ce low pulse, ce high recovery
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.s1   = dq_i;       // two-stage sync of device data
    nxt_st.s2   = st_ff.s1;
    case (st_ff.st)
      ST_IDLE:
      begin
        if (cyc.req)
        begin
          nxt_st.a     = cyc.addr;
          nxt_st.d     = cyc.wdata;
          nxt_st.dq_oe = cyc.wr;
          nxt_st.oe_n  = 1'b1;
          nxt_st.st    = cyc.wr ? ST_LOW : ST_RDLOW;
          nxt_st.cnt   = cyc.wr ? WP_CYC : RD_CYC;
        end
      end
      ST_LOW:
      begin
        nxt_st.ce_n = 1'b0;  // address latched by device on this fall
        nxt_st.cnt  = st_ff.cnt - 8'h01;
        if (st_ff.cnt == 8'h01)
        begin
          nxt_st.st  = ST_HIGH;
          nxt_st.cnt = WPH_CYC;
        end
      end
      ST_HIGH:
      begin
        // pulse well over 10 ns so the glitch filter never drops it
        nxt_st.ce_n = 1'b1;  // data latched on this rise
        nxt_st.cnt  = st_ff.cnt - 8'h01;
        if (st_ff.cnt == 8'h01)
        begin
          nxt_st.st    = ST_IDLE;
          nxt_st.dq_oe = 1'b0;
          nxt_st.done  = 1'b1;
        end
      end
      ST_RDLOW:
      begin
        // fresh ce and oe fall per read so status is relatched
        nxt_st.ce_n = 1'b0;
        nxt_st.oe_n = 1'b0;
        nxt_st.cnt  = st_ff.cnt - 8'h01;
        if (st_ff.cnt == 8'h01)
          nxt_st.st = ST_RDEND;
      end
      ST_RDEND:
      begin
        nxt_st.rd   = st_ff.s2;
        nxt_st.ce_n = 1'b1;
        nxt_st.oe_n = 1'b1;
        nxt_st.st   = ST_HIGH;
        nxt_st.cnt  = WPH_CYC;
      end
      default: nxt_st.st = ST_IDLE;
    endcase
    if (rst_i)
    begin
      nxt_st      = '0;
      nxt_st.ce_n = 1'b1;
      nxt_st.oe_n = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge clk_i)
    st_ff <= nxt_st;

  assign cyc.done  = st_ff.done;
  assign cyc.rdata = st_ff.rd;
  assign dq_o      = st_ff.d;
  assign dq_oe_o   = st_ff.dq_oe;
  assign addr_o    = st_ff.a;
  assign ce_n_o    = st_ff.ce_n;
  assign oe_n_o    = st_ff.oe_n;
endmodule

// [fpsa_host_ctrl.sv]
// host controller: sequences protect, unprotect, abort, id and status commands
// Notes on behaviour
// - two reserved status bits read zero; host masks them when polling.
// - lock: two unlocks, setup, two unlocks, 20H, with high supply.
// - host leaves identification mode with read or reset command.
// - unprotect: first five lock cycles then 40H; then status-read mode.
// - host writes array read to leave abort, then clears status.
// - writes need chip enable low, output enable high, high supply; host raises the supply only for lock and unprotect.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module fpsa_host_ctrl
  import fpsa_pkg::*;
(
  input  wire logic        clk_i,     // 200 MHz clock
  input  wire logic        rst_i,     // synchronous reset, active high
  input  wire logic [3:0]  addr_i,    // register address
  input  wire logic [31:0] wdata_i,   // register write data
  input  wire logic        wr_i,      // write strobe
  input  wire logic        rd_i,      // read strobe
  output logic      [31:0] rdata_o,   // read data, one cycle later
  input  wire logic [7:0]  dq_i,      // flash data in
  output logic      [7:0]  dq_o,      // flash data out
  output logic             dq_oe_o,   // flash data drive enable
  output logic      [19:0] faddr_o,   // flash address
  output logic             ce_n_o,    // flash chip enable, active low
  output logic             oe_n_o,    // flash output enable, active low
  output logic             vpp_en_o   // high programming supply enable
);
  fpsa_cyc_if cyc ();

  typedef struct packed {
    logic        busy;
    logic        done;
    logic        err;
    fpsa_op_t    op;
    logic [2:0]  idx;
    logic [2:0]  last;
    logic [19:0] tgt;
    logic [7:0]  rdat;
    logic        req;
    logic        wr;
    logic [19:0] a;
    logic [7:0]  d;
    logic        wait_c;
    logic        vpp;
    logic        abort_pend;
    logic [31:0] rdata;
  } hc_t;
  hc_t st_ff, nxt_st;

  // one command sequence step: address and byte for cycle idx of op
  function automatic logic [27:0] step(input fpsa_op_t op, input logic [2:0] i,
                                       input logic [19:0] tgt);
    logic [27:0] r;
    r = {UNLOCK_ADDR1, CMD_UNLOCK1};
    case (i)
      3'h0: r = {UNLOCK_ADDR1, CMD_UNLOCK1};
      3'h1: r = {UNLOCK_ADDR2, CMD_UNLOCK2};
      3'h2: r = (op == OP_ABORT) ? {UNLOCK_ADDR1, CMD_ABORT}
                                 : {UNLOCK_ADDR1, CMD_SETUP};
      3'h3: r = {UNLOCK_ADDR1, CMD_UNLOCK1};
      3'h4: r = {UNLOCK_ADDR2, CMD_UNLOCK2};
      // sector address presented on the sixth cycle
      3'h5: r = (op == OP_LOCK) ? {tgt, CMD_LOCK} : {tgt, CMD_UNPROTECT};
      default: r = {UNLOCK_ADDR1, CMD_UNLOCK1};
    endcase
    return r;
  endfunction

  // order handling, cycle stepping and register reads
  always_comb
  begin
    logic [27:0] s;
    s            = step(st_ff.op, st_ff.idx, st_ff.tgt);
    nxt_st       = st_ff;
    nxt_st.req   = 1'b0;
    nxt_st.rdata = 32'h0000_0000;
    if (rd_i)
    begin
      case (addr_i)
        REG_STATUS: nxt_st.rdata = {21'h0, st_ff.abort_pend, st_ff.vpp, st_ff.err,
                                    st_ff.done, st_ff.busy, 3'h0, st_ff.op};
        REG_DATA:   nxt_st.rdata = {24'h0, st_ff.rdat};
        default:    nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // accept a new order only while idle; orders during busy are dropped
    if (wr_i && addr_i == REG_CTRL && !st_ff.busy)
    begin
      nxt_st.busy = 1'b1;
      nxt_st.done = 1'b0;
      nxt_st.err  = 1'b0;
      nxt_st.op   = fpsa_op_t'(wdata_i[2:0]);
      nxt_st.tgt  = wdata_i[27:8];
      nxt_st.idx  = 3'h0;
      case (fpsa_op_t'(wdata_i[2:0]))
        OP_LOCK, OP_UNPROTECT: nxt_st.last = 3'h5;  // six cycles
        OP_ABORT:              nxt_st.last = 3'h2;  // three cycles
        default:               nxt_st.last = 3'h0;
      endcase
      // supply raised for a protect change from order acceptance until its sixth cycle is done
      nxt_st.vpp = (wdata_i[2:0] == OP_LOCK) || (wdata_i[2:0] == OP_UNPROTECT);
    end
    else if (st_ff.busy && !st_ff.wait_c)
    begin
      nxt_st.req    = 1'b1;
      nxt_st.wait_c = 1'b1;
      nxt_st.wr     = 1'b1;
      case (st_ff.op)
        OP_LOCK, OP_UNPROTECT, OP_ABORT:
        begin
          nxt_st.a = s[27:8];
          nxt_st.d = s[7:0];
        end
        OP_READ_ARR:
        begin
          nxt_st.a = UNLOCK_ADDR1;
          nxt_st.d = CMD_READ_ARRAY;  // also ends id and abort modes
        end
        OP_CLR_STAT:
        begin
          nxt_st.a = UNLOCK_ADDR1;
          nxt_st.d = CMD_CLR_STATUS;  // only way to drop fail bits
        end
        OP_READ_ID:
        begin
          nxt_st.a = UNLOCK_ADDR1;
          nxt_st.d = CMD_READ_ID;
        end
        OP_POLL:
        begin
          nxt_st.a = UNLOCK_ADDR1;
          nxt_st.d = CMD_READ_STATUS;
        end
        default:
        begin
          nxt_st.wr = 1'b0;           // plain read at target address
          nxt_st.a  = st_ff.tgt;
        end
      endcase
    end
    else if (st_ff.busy && cyc.done)
    begin
      nxt_st.wait_c = 1'b0;
      if (st_ff.op == OP_POLL && st_ff.wr)
      begin
        nxt_st.wr     = 1'b0;
        nxt_st.wait_c = 1'b1;
        nxt_st.req    = 1'b1;         // follow with one read, fresh enables
        nxt_st.a      = st_ff.tgt;
      end
      else if (st_ff.idx == st_ff.last)
      begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.vpp  = 1'b0;
        if (!st_ff.wr)
        begin
          nxt_st.rdat = cyc.rdata;
          if (st_ff.op == OP_POLL)
          begin
            // reserved bits dropped before judging
            nxt_st.rdat = cyc.rdata & ST_POLL_MASK;
            nxt_st.err  = cyc.rdata[ST_ERASE_FAIL] | cyc.rdata[ST_PROG_FAIL];
            nxt_st.busy = ~cyc.rdata[ST_READY_BIT];  // re-poll while busy
            nxt_st.done = cyc.rdata[ST_READY_BIT];
            nxt_st.wr   = 1'b1;
          end
        end
        // abort leaves device in abort mode until array read and clear
        if (st_ff.op == OP_ABORT)
          nxt_st.abort_pend = 1'b1;
        if (st_ff.op == OP_CLR_STAT)
          nxt_st.abort_pend = 1'b0;
      end
      else
        nxt_st.idx = st_ff.idx + 3'h1;
    end
    if (rst_i)
      nxt_st = '0;
  end

  // single state register
  always_ff @(posedge clk_i)
    st_ff <= nxt_st;

  assign cyc.req   = st_ff.req;
  assign cyc.wr    = st_ff.wr;
  assign cyc.addr  = st_ff.a;
  assign cyc.wdata = st_ff.d;
  assign rdata_o   = st_ff.rdata;
  assign vpp_en_o  = st_ff.vpp;

  fpsa_pin_eng u_eng (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cyc     (cyc),
    .dq_i    (dq_i),
    .dq_o    (dq_o),
    .dq_oe_o (dq_oe_o),
    .addr_o  (faddr_o),
    .ce_n_o  (ce_n_o),
    .oe_n_o  (oe_n_o)
  );
endmodule

// [fpsa_host_ctrl_checker.sv]
// pin-level assertions for the flash host controller
`timescale 1ns/1ps
module fpsa_host_ctrl_checker
  import fpsa_pkg::*;
(
  input wire logic        clk_i,    // clock
  input wire logic        rst_i,    // reset
  input wire logic [7:0]  dq_o,     // flash data out
  input wire logic        dq_oe_o,  // data drive enable
  input wire logic [19:0] faddr_o,  // flash address
  input wire logic        ce_n_o,   // chip enable
  input wire logic        oe_n_o,   // output enable
  input wire logic        vpp_en_o  // supply request
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // reset must leave the flash deselected so no stray write starts
  AST_RESET_IDLE: assert property (disable iff (1'b0) rst_i |=> ce_n_o && oe_n_o && !dq_oe_o && !vpp_en_o)
    else $error("pins not idle after reset");
  AST_NO_DRIVE_READ: assert property (dq_oe_o |-> oe_n_o)
    else $error("data driven while output enable low");
  AST_READ_BOTH: assert property (!oe_n_o |-> !ce_n_o && !dq_oe_o)
    else $error("read without chip enable");
  AST_CE_WIDTH: assert property ($fell(ce_n_o) |=> !ce_n_o [*8])
    else $error("chip enable pulse too narrow");
  AST_CE_TOGGLE: assert property ($rose(ce_n_o) |=> ce_n_o [*7])
    else $error("chip enable high time too short");
  AST_ADDR_SETUP: assert property ($fell(ce_n_o) |-> $stable(faddr_o))
    else $error("address moved at chip enable fall");
  AST_WR_STABLE: assert property (!ce_n_o && dq_oe_o && !$past(ce_n_o) |-> $stable(faddr_o) && $stable(dq_o))
    else $error("write cycle changed under chip enable");
  AST_VPP_LOCK: assert property ($fell(ce_n_o) && dq_oe_o && (dq_o == CMD_LOCK || dq_o == CMD_UNPROTECT) |-> vpp_en_o)
    else $error("lock command without high supply");
  AST_READ_HOLD: assert property ($fell(oe_n_o) |=> !oe_n_o [*8])
    else $error("read pulse too short");
  COV_WRITE: cover property ($fell(ce_n_o) && dq_oe_o);
  COV_READ: cover property ($fell(oe_n_o));
  COV_VPP: cover property ($rose(vpp_en_o));
endmodule

bind fpsa_host_ctrl fpsa_host_ctrl_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .dq_o(dq_o),
  .dq_oe_o(dq_oe_o), .faddr_o(faddr_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .vpp_en_o(vpp_en_o));

// [fpsa_flash_model.sv]
// behavioural flash device answering the host controller pins
`timescale 1ns/1ps
module fpsa_flash_model
  import fpsa_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h3C,  // arbitrary maker code
  parameter logic [7:0] DEV_CODE = 8'h5A,  // arbitrary part code
  parameter int         BUSY_NS  = 2000    // internal lock run time
)
(
  input  wire logic        ce_n_i,   // chip enable, active low
  input  wire logic        oe_n_i,   // output enable, active low
  input  wire logic [19:0] addr_i,   // address pins
  input  wire logic [7:0]  dq_i,     // data from host
  input  wire logic        dq_oe_i,  // host drives data
  input  wire logic        vpp_i,    // high supply present
  input  wire logic        vcc_ok_i, // supply above the lockout threshold
  output logic      [7:0]  dq_o      // data to host
);
  logic [47:0] hist     = '0;    // last six command bytes
  logic [19:0] sec_addr = '0;    // address taken at chip-enable fall
  logic [19:0] lock_sec = '0;    // sector held for the running lock
  logic [1:0]  mode     = 2'd0;  // 0 array, 1 status, 2 id
  logic        busy     = 1'b0;  // internal machine running
  logic        efail    = 1'b0;  // erase-type fail
  logic        pfail    = 1'b0;  // program-type fail
  logic        prot     = 1'b0;  // sector 0 or 15 locked
  logic        kind     = 1'b0;  // 1 erase-type (lock), 0 program-type
  logic [7:0]  rd_q     = 8'hFF; // frozen read value
  logic [7:0]  last     = 8'hFF; // last value driven
  time         t_fall   = 0;     // chip enable fall time
  event        go;               // internal run started
  // address on the falling edge; a glitch is judged by the low time
  always @(negedge ce_n_i)
  begin
    sec_addr = addr_i;
    t_fall = $time;
  end
  // command byte on the rising edge, only with output enable high
  always @(posedge ce_n_i)
    if (vcc_ok_i && oe_n_i && dq_oe_i && ($time - t_fall) >= 10)
    begin
      hist = {hist[39:0], dq_i};
      if (hist[23:0] == {CMD_UNLOCK1, CMD_UNLOCK2, CMD_ABORT} && busy)
      begin
        busy = 1'b0;
        efail = efail | kind;
        pfail = pfail | !kind;
      end
      else if (vpp_i && hist[47:8] == {CMD_UNLOCK1, CMD_UNLOCK2, CMD_SETUP, CMD_UNLOCK1,
               CMD_UNLOCK2} && (dq_i == CMD_LOCK || dq_i == CMD_UNPROTECT))
      begin
        kind = (dq_i == CMD_LOCK);
        lock_sec = sec_addr; // later cycles must not move the target
        busy = 1'b1;
        mode = 2'd1;
        -> go;
      end
      else if (dq_i == CMD_READ_ARRAY)
        mode = 2'd0;
      else if (dq_i == CMD_READ_STATUS)
        mode = 2'd1;
      else if (dq_i == CMD_READ_ID)
        mode = 2'd2;
      else if (dq_i == CMD_CLR_STATUS)
        {efail, pfail} = 2'b00;
    end
  // run ends unless aborted; only sectors 0 and 15 show in the protect bit
  always @(go)
  begin
    #(BUSY_NS);
    if (busy && (lock_sec[19:15] == 5'h00 || lock_sec[19:15] == 5'h0F))
      prot = kind;
    busy = 1'b0;
  end
  // supply dip drops any run and falls back to array read
  always @(negedge vcc_ok_i)
  begin
    busy = 1'b0;
    mode = 2'd0;
  end
  // value frozen at the later enable fall so a late change cannot tear a read
  always @(negedge (ce_n_i | oe_n_i))
    rd_q = (mode == 2'd1) ? {!busy, 1'b0, efail, pfail, prot, 3'b000} :
           (mode == 2'd0) ? 8'hFF : (addr_i[7:0] == 8'h00) ? MFR_CODE :
           (addr_i[7:0] == 8'h01) ? DEV_CODE : {7'h00, prot};
  always @(posedge (ce_n_i | oe_n_i))
    last = rd_q;
  // released bus shows the inverse of the last value, never a stale copy
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd_q : ~last;
endmodule

// [fpsa_host_ctrl_tb.sv]
// self-checking testbench for the flash host controller
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module fpsa_host_ctrl_tb;
  import fpsa_pkg::*;
  localparam logic [7:0] MFR = 8'h3C; // arbitrary maker code
  localparam logic [7:0] DEV = 8'h5A; // arbitrary part code
  logic        clk_i;
  logic        rst_i = 1'b1;
  logic [3:0]  addr  = '0;
  logic [31:0] wdata = '0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        vcc_ok = 1'b1;
  logic [31:0] rdata;
  logic [7:0]  dq_in, dq_out;
  logic [19:0] faddr;
  logic        dq_oe, ce_n, oe_n, vpp;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  fpsa_host_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(dq_oe),
    .faddr_o(faddr), .ce_n_o(ce_n), .oe_n_o(oe_n), .vpp_en_o(vpp));
  fpsa_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash_u (.ce_n_i(ce_n), .oe_n_i(oe_n),
    .addr_i(faddr), .dq_i(dq_out), .dq_oe_i(dq_oe), .vpp_i(vpp), .vcc_ok_i(vcc_ok),
    .dq_o(dq_in));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic conclude();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    d = rdata;
    @(posedge clk_i);
  endtask
  // one order, then bounded wait for done with busy clear
  task automatic run_op(input fpsa_op_t op, input logic [19:0] fa);
    logic [31:0] s;
    int n;
    bus_wr(REG_CTRL, {4'h0, fa, 5'h00, op});
    for (n = 0; n < 20000; n++)
    begin
      bus_rd(REG_STATUS, s);
      if (s[7] === 1'b1 && s[6] === 1'b0)
        break;
    end
    if (n == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic data_is(input fpsa_op_t op, input logic [19:0] fa, input logic [7:0] e);
    logic [31:0] s;
    run_op(op, fa);
    bus_rd(REG_DATA, s);
    `CHK(s[7:0], e)
  endtask
  task automatic t_reset();
    `CHK({ce_n, oe_n, dq_oe, vpp}, 4'b1100)
    data_is(OP_READ, 20'h00000, 8'hFF);
  endtask
  task automatic t_lock_id();
    run_op(OP_LOCK, 20'h00000);
    data_is(OP_POLL, 20'h00000, 8'h88);
    run_op(OP_READ_ID, 20'h00000);
    data_is(OP_READ, ID_MFR_ADDR, MFR);
    data_is(OP_READ, ID_DEV_ADDR, DEV);
    data_is(OP_READ, ID_PROT_ADDR, 8'h01);
    run_op(OP_READ_ARR, 20'h00000);
    data_is(OP_READ, 20'h00000, 8'hFF);
  endtask
  task automatic t_unprotect();
    run_op(OP_UNPROTECT, 20'h00000);
    data_is(OP_POLL, 20'h00000, 8'h80);
  endtask
  // abort a sector 15 lock mid-run: erase-type fail, no protection
  task automatic t_abort();
    logic [31:0] s;
    run_op(OP_LOCK, 20'h78000);
    run_op(OP_ABORT, 20'h00000);
    bus_rd(REG_STATUS, s);
    `CHK(s[10], 1'b1)
    data_is(OP_POLL, 20'h00000, 8'hA0);
    bus_rd(REG_STATUS, s);
    `CHK(s[8], 1'b1)
    run_op(OP_READ_ARR, 20'h00000);
    data_is(OP_POLL, 20'h00000, 8'hA0);
    run_op(OP_CLR_STAT, 20'h00000);
    bus_rd(REG_STATUS, s);
    `CHK(s[10], 1'b0)
    data_is(OP_POLL, 20'h00000, 8'h80);
  endtask
  // supply dip: id mode dropped and writes ignored until supply returns
  task automatic t_lockout();
    run_op(OP_READ_ID, 20'h00000);
    vcc_ok <= 1'b0;
    run_op(OP_READ_ID, 20'h00000);
    data_is(OP_READ, ID_MFR_ADDR, 8'hFF);
    vcc_ok <= 1'b1;
    run_op(OP_READ_ID, 20'h00000);
    data_is(OP_READ, ID_MFR_ADDR, MFR);
    run_op(OP_READ_ARR, 20'h00000);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_lock_id();
    t_unprotect();
    t_abort();
    t_lockout();
    conclude();
  end
endmodule
